// ### src/ppc_pkg.sv
//==========================================================
// Purpose: Shared constants and types for the port pin configuration block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Register indices are word indices; byte address is index times four
//==========================================================
package ppc_pkg;

  //==========================================================
  // Geometry
  //==========================================================
  localparam int NPIN = 6;
  localparam int REG_W = 8;
  localparam int ADDR_W = 18;
  localparam int PIN_RCM = 5;
  localparam int PIN_PWM = 4;

  //==========================================================
  // Register indices and byte addresses
  //==========================================================
  localparam logic [15:0] IDX_DATA = 16'hf218;
  localparam logic [15:0] IDX_DIR = 16'hf219;
  localparam logic [15:0] IDX_CON0 = 16'hf21a;
  localparam logic [15:0] IDX_CON1 = 16'hf21b;
  localparam logic [15:0] IDX_MOD0 = 16'hf21c;
  localparam logic [15:0] IDX_MOD1 = 16'hf21d;
  localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIR = {IDX_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CON0 = {IDX_CON0, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CON1 = {IDX_CON1, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MOD0 = {IDX_MOD0, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MOD1 = {IDX_MOD1, 2'h0};
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  //==========================================================
  // Field codes
  //==========================================================
  localparam logic DIR_OUT = 1'b0;
  localparam logic [1:0] CFG_HIZ = 2'h0;
  localparam logic [1:0] CFG_PCH = 2'h1;
  localparam logic [1:0] CFG_NCH = 2'h2;
  localparam logic [1:0] CFG_CMOS = 2'h3;
  localparam logic [1:0] CFG_PULL_DN = 2'h1;
  localparam logic [1:0] CFG_PULL_UP = 2'h2;
  localparam logic [1:0] FSEL_GPIO = 2'h0;
  localparam logic [1:0] FSEL_SECOND = 2'h1;
  localparam logic [1:0] FSEL_THIRD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FN_GPIO,
    FN_ANALOG,
    FN_DIGALT,
    FN_PROHIB
  } ppc_func_t;

  typedef enum logic [2:0] {
    RG_DATA,
    RG_DIR,
    RG_CON0,
    RG_CON1,
    RG_MOD0,
    RG_MOD1,
    RG_NONE
  } ppc_reg_t;

endpackage

// ### src/ppc_pin_cell.sv
//==========================================================
// Purpose: Combinational pad control for one port pin
// Assumes: Caller registers every output before it reaches a pad
// Notes:   Open-drain modes drive only one level; the other is released
//==========================================================
`timescale 1ns/1ps
module ppc_pin_cell
  import ppc_pkg::*;
(
  input wire logic dir, // Direction bit, 0 output
  input wire logic [1:0] cfg, // Drive or pull code
  input wire ppc_pkg::ppc_func_t func, // Decoded function
  input wire logic data, // Data register bit
  input wire logic alt, // Alternate digital source
  output logic pad_out, // Level to drive
  output logic pad_oe, // Drive enable
  output logic pull_up, // Pull-up enable
  output logic pull_dn, // Pull-down enable
  output logic analog // Converter connection enable
);
  logic dval;

  always_comb begin
    unique case (func)
      FN_DIGALT: dval = alt;
      FN_PROHIB: dval = 1'b0;
      default: dval = data;
    endcase
    pad_out = 1'b0;
    pad_oe = 1'b0;
    pull_up = 1'b0;
    pull_dn = 1'b0;
    analog = (func == FN_ANALOG);
    if (dir == DIR_OUT) begin
      // Converter owns the pin while connected
      if (func != FN_ANALOG) begin
        unique case (cfg)
          CFG_HIZ: pad_oe = 1'b0;
          CFG_PCH: begin
            pad_out = 1'b1;
            pad_oe = dval;
          end
          CFG_NCH: begin
            pad_out = 1'b0;
            pad_oe = ~dval;
          end
          CFG_CMOS: begin
            pad_out = dval;
            pad_oe = 1'b1;
          end
        endcase
      end
    end else begin
      pull_dn = (cfg == CFG_PULL_DN);
      pull_up = (cfg == CFG_PULL_UP);
    end
  end

endmodule

// ### src/ppc_port_top.sv
//==========================================================
// Purpose: Port pin configuration block with AXI4-Lite register access
// Assumes: Pad inputs synchronous to SYS_CLK; one write and one read in flight
// Notes:   Pad controls lag a register write by one cycle
//          Unmapped addresses get an error response and change nothing
//==========================================================
// Operation
// - Drive/pull code meaning depends on the pin's direction bit.
// - Code high bit from second control register, low bit from first.
// - Output: 00 hi-Z, 01 P open drain, 10 N open drain, 11 CMOS.
// - Input: 00 and 11 hi-Z, 01 pull-down, 10 pull-up.
// - After reset every pin is a hi-Z output.
// - Control registers: first takes 8/16-bit access, second byte only; reset 00.
// - Mode registers: first takes 8/16-bit access, second byte only; reset 00.
// - Two-bit function code per pin, high from second mode register.
// - Pin 5: 00 GPIO, 01 oscillation monitor, 1x prohibited.
// - Pin 4: 00 GPIO, 01 sensor connection, 10 pulse output, 11 prohibited.
// - Direction 0 is output, 1 input; output after reset.
// - Output pins drive the data bit; input pins read back the pad level.
// - Prohibited code on output ignores data: hi-Z or P gives hi-Z, else low.
`timescale 1ns/1ps
module ppc_port_top
  import ppc_pkg::*;
#(
  parameter int NPIN_P = ppc_pkg::NPIN, // Number of port pins
  parameter int ADDR_W_P = ppc_pkg::ADDR_W // Byte address width
)
(
  input wire logic SYS_CLK, // System clock
  input wire logic RESET_N, // Asynchronous reset, active low
  input wire logic [ADDR_W_P-1:0] S_AXI_AWADDR, // Write address
  input wire logic [2:0] S_AXI_AWPROT, // Write protection, unused
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [ADDR_W_P-1:0] S_AXI_ARADDR, // Read address
  input wire logic [2:0] S_AXI_ARPROT, // Read protection, unused
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY, // Read data ready
  input wire logic [NPIN_P-1:0] PAD_IN, // Pad input levels
  output logic [NPIN_P-1:0] PAD_OUT, // Pad output levels
  output logic [NPIN_P-1:0] PAD_OE, // Pad drive enables
  output logic [NPIN_P-1:0] PAD_PULL_UP, // Pull-up enables
  output logic [NPIN_P-1:0] PAD_PULL_DN, // Pull-down enables
  output logic [NPIN_P-1:0] PAD_ANALOG, // Converter connection enables
  input wire logic RC_OSC_MONITOR, // Oscillation monitor from converter
  input wire logic PULSE_WIDTH_OUT_CH0 // Pulse-width channel 0 output
);
  import ppc_pkg::*;

  //==========================================================
  // State
  //==========================================================
  // One record so a single flop bank holds all state except the reset synchronizer flops
  typedef struct packed {
    // Software-visible registers
    logic [REG_W-1:0] port_data_reg;
    logic [REG_W-1:0] port_direction_reg;
    logic [REG_W-1:0] port_drive_cfg_low;
    logic [REG_W-1:0] port_drive_cfg_high;
    logic [REG_W-1:0] port_function_sel_low;
    logic [REG_W-1:0] port_function_sel_high;

    // Bus handshake
    logic aw_got;
    logic [ADDR_W_P-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;

    // Registered pad controls
    logic [NPIN_P-1:0] pad_out;
    logic [NPIN_P-1:0] pad_oe;
    logic [NPIN_P-1:0] pull_up;
    logic [NPIN_P-1:0] pull_dn;
    logic [NPIN_P-1:0] analog;
  } ppc_state_t;

  ppc_state_t s;
  ppc_state_t next_s;
  logic rst_meta;
  logic rst_n_sync;

  //==========================================================
  // Decoders
  //==========================================================
  // Exact match only; partial or aliased addresses are refused
  function automatic ppc_reg_t reg_decode(input logic [ADDR_W_P-1:0] addr);
    ppc_reg_t r;
    unique case (addr)
      ADDR_DATA: r = RG_DATA;
      ADDR_DIR: r = RG_DIR;
      ADDR_CON0: r = RG_CON0;
      ADDR_CON1: r = RG_CON1;
      ADDR_MOD0: r = RG_MOD0;
      ADDR_MOD1: r = RG_MOD1;
      default: r = RG_NONE;
    endcase
    return r;
  endfunction

  // Only pins 4 and 5 carry digital alternates
  function automatic ppc_func_t pin_func(input int idx, input logic [1:0] code);
    ppc_func_t f;
    f = FN_PROHIB;
    if (code == FSEL_GPIO) begin
      f = FN_GPIO;
    end else if (code == FSEL_SECOND) begin
      f = (idx == PIN_RCM) ? FN_DIGALT : FN_ANALOG;
    end else if (code == FSEL_THIRD && idx == PIN_PWM) begin
      f = FN_DIGALT;
    end
    return f;
  endfunction

  //==========================================================
  // Reset release
  //==========================================================
  // Assertion stays asynchronous; release is aligned to the clock
  // so no flop leaves reset a cycle before its neighbours
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  //==========================================================
  // Pin cells
  //==========================================================
  // Raw cell results; the next-state record registers them
  logic [NPIN_P-1:0] cell_out;
  logic [NPIN_P-1:0] cell_oe;
  logic [NPIN_P-1:0] cell_pu;
  logic [NPIN_P-1:0] cell_pd;
  logic [NPIN_P-1:0] cell_an;
  logic [NPIN_P-1:0] alt_src;
  logic [NPIN_P-1:0] data_view;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN_P; gi++) begin : g_pin
      // Digital alternates exist on pins 4 and 5 only
      if (gi == PIN_RCM) begin : g_rcm
        assign alt_src[gi] = RC_OSC_MONITOR;
      end else if (gi == PIN_PWM) begin : g_pwm
        assign alt_src[gi] = PULSE_WIDTH_OUT_CH0;
      end else begin : g_none
        assign alt_src[gi] = 1'b0;
      end

      // Input pins read the pad, output pins read the stored bit
      assign data_view[gi] = (s.port_direction_reg[gi] == DIR_OUT) ?
        s.port_data_reg[gi] : PAD_IN[gi];

      // Pure logic per pin; nothing reaches a pad unregistered
      ppc_pin_cell u_cell (
        .dir(s.port_direction_reg[gi]),
        .cfg({s.port_drive_cfg_high[gi], s.port_drive_cfg_low[gi]}),
        .func(pin_func(gi, {s.port_function_sel_high[gi], s.port_function_sel_low[gi]})),
        .data(s.port_data_reg[gi]),
        .alt(alt_src[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi]),
        .pull_up(cell_pu[gi]),
        .pull_dn(cell_pd[gi]),
        .analog(cell_an[gi])
      );
    end
  endgenerate

  //==========================================================
  // Next state
  //==========================================================
  always_comb begin
    ppc_reg_t wsel;
    ppc_reg_t rsel;
    logic [7:0] lo;
    logic [7:0] hi;
    // Write decode uses the held address, read decode the live one
    wsel = reg_decode(s.aw_addr);
    rsel = reg_decode(S_AXI_ARADDR);
    // Defaults only; the commit branch reloads the lanes from held data
    lo = S_AXI_WDATA[7:0];
    hi = S_AXI_WDATA[15:8];
    // Hold everything unless a branch below says otherwise
    next_s = s;

    // Write address and data are taken in either order
    if (S_AXI_AWVALID && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = S_AXI_WDATA;
      next_s.w_strb = S_AXI_WSTRB;
    end
    // Response leaves on its handshake edge
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // Commit once both halves are held; a pending response blocks another
    if (s.aw_got && s.w_got && !s.bvalid) begin
      lo = s.w_data[7:0];
      hi = s.w_data[15:8];
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (wsel)
        RG_DATA: begin
          if (s.w_strb[0]) next_s.port_data_reg = lo;
        end
        RG_DIR: begin
          if (s.w_strb[0]) next_s.port_direction_reg = lo;
        end
        RG_CON0: begin
          if (s.w_strb[0]) next_s.port_drive_cfg_low = lo;
          if (s.w_strb[1]) next_s.port_drive_cfg_high = hi;
        end
        RG_CON1: begin
          if (s.w_strb[0]) next_s.port_drive_cfg_high = lo;
        end
        RG_MOD0: begin
          if (s.w_strb[0]) next_s.port_function_sel_low = lo;
          if (s.w_strb[1]) next_s.port_function_sel_high = hi;
        end
        RG_MOD1: begin
          if (s.w_strb[0]) next_s.port_function_sel_high = lo;
        end
        // Unmapped: no register changes, error answer
        RG_NONE: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read path runs beside the write path and shares no handshake state with it
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    // Read data is captured at the take edge, then held for the master
    if (S_AXI_ARVALID && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      // Unused lanes read as zero
      next_s.rdata = 32'h0000_0000;
      unique case (rsel)
        RG_DATA: begin
          next_s.rdata[7:0] = {s.port_data_reg[7:NPIN_P], data_view};
        end
        RG_DIR: begin
          next_s.rdata[7:0] = s.port_direction_reg;
        end
        RG_CON0: begin
          next_s.rdata[15:0] = {s.port_drive_cfg_high, s.port_drive_cfg_low};
        end
        RG_CON1: begin
          next_s.rdata[7:0] = s.port_drive_cfg_high;
        end
        RG_MOD0: begin
          next_s.rdata[15:0] = {s.port_function_sel_high, s.port_function_sel_low};
        end
        RG_MOD1: begin
          next_s.rdata[7:0] = s.port_function_sel_high;
        end
        RG_NONE: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Ready flags are registered so every bus output comes from a flop
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Upper register bits never reach the cells
    next_s.pad_out = cell_out;
    next_s.pad_oe = cell_oe;
    next_s.pull_up = cell_pu;
    next_s.pull_dn = cell_pd;
    next_s.analog = cell_an;
  end

  //==========================================================
  // State register
  //==========================================================
  // Every field clears: pads come up hi-Z and the bus idles
  always_ff @(posedge SYS_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s <= '0;
      // Register fields named again so their reset values stay visible
      s.port_data_reg <= REG_RESET;
      s.port_direction_reg <= REG_RESET;
      s.port_drive_cfg_low <= REG_RESET;
      s.port_drive_cfg_high <= REG_RESET;
      s.port_function_sel_low <= REG_RESET;
      s.port_function_sel_high <= REG_RESET;
    end else begin
      s <= next_s;
    end
  end

  //==========================================================
  // Outputs
  //==========================================================
  // Plain wires from the record; no logic after the flops
  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY = s.wready;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RRESP = s.rresp;
  assign S_AXI_RDATA = s.rdata;
  assign PAD_OUT = s.pad_out;
  assign PAD_OE = s.pad_oe;
  assign PAD_PULL_UP = s.pull_up;
  assign PAD_PULL_DN = s.pull_dn;
  assign PAD_ANALOG = s.analog;

endmodule

// ### testbench/ppc_port_props.sv
// Purpose: Concurrent checks on the port configuration top ports
// Assumes: One clock domain, RESET_N active low
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
module ppc_port_props #(
  parameter int NPIN_P = 6 // Number of port pins
)(
  input wire logic SYS_CLK, // Clock
  input wire logic RESET_N, // Reset, active low
  input wire logic S_AXI_AWVALID, // AW valid
  input wire logic S_AXI_AWREADY, // AW ready
  input wire logic S_AXI_WVALID, // W valid
  input wire logic S_AXI_WREADY, // W ready
  input wire logic [1:0] S_AXI_BRESP, // B code
  input wire logic S_AXI_BVALID, // B valid
  input wire logic S_AXI_BREADY, // B ready
  input wire logic S_AXI_ARVALID, // AR valid
  input wire logic S_AXI_ARREADY, // AR ready
  input wire logic [31:0] S_AXI_RDATA, // Read data
  input wire logic S_AXI_RVALID, // R valid
  input wire logic S_AXI_RREADY, // R ready
  input wire logic [NPIN_P-1:0] PAD_OE, // Drive enables
  input wire logic [NPIN_P-1:0] PAD_PULL_UP, // Pull-ups
  input wire logic [NPIN_P-1:0] PAD_PULL_DN, // Pull-downs
  input wire logic [NPIN_P-1:0] PAD_ANALOG // Converter links
);
  //==========================================================
  // Checks
  //==========================================================
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  reset_pads_off_a: assert property ($rose(RESET_N) |-> (PAD_OE == '0) [*2])
    else $error("pad driven right after reset");
  pull_no_drive_a: assert property (((PAD_PULL_UP | PAD_PULL_DN) & PAD_OE) == '0)
    else $error("pull enabled on a driven pin");
  pull_exclusive_a: assert property ((PAD_PULL_UP & PAD_PULL_DN) == '0)
    else $error("both pulls on one pin");
  analog_no_drive_a: assert property ((PAD_ANALOG & PAD_OE) == '0)
    else $error("converter pin driven");
  aw_hold_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("write address ready stayed high");
  write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  bresp_stands_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  read_stands_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
endmodule

bind ppc_port_top ppc_port_props #(.NPIN_P(NPIN_P)) u_props (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PAD_OE(PAD_OE), .PAD_PULL_UP(PAD_PULL_UP),
  .PAD_PULL_DN(PAD_PULL_DN), .PAD_ANALOG(PAD_ANALOG));

// ### testbench/ppc_board_model.sv
// Purpose: Board circuitry on the port pads
// Assumes: Board drives only pins the bench enables
// Notes: A floating pin toggles so no stale level reads back
`timescale 1ns/1ps
module ppc_board_model (
  input wire logic clk, // Clock
  input wire logic [5:0] pad_out, // Device level
  input wire logic [5:0] pad_oe, // Device drive
  input wire logic [5:0] pull_up, // Pull-up on
  input wire logic [5:0] pull_dn, // Pull-down on
  input wire logic [5:0] ext_en, // Board drives
  input wire logic [5:0] ext_val, // Board level
  output logic [5:0] pad_in // Pin level
);
  logic toggle = 1'b0;
  always @(posedge clk) toggle <= ~toggle;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pull_up[i]) pad_in[i] = 1'b1;
      else if (pull_dn[i]) pad_in[i] = 1'b0;
      else pad_in[i] = toggle;
    end
  end
endmodule

// ### testbench/ppc_port_top_bench.sv
// Purpose: Self-checking bench for the port configuration block
// Assumes: Bench is the bus master, board model on the pads
// Notes: Random settings from a fixed seed plus bus corner cases
`timescale 1ns/1ps
module ppc_port_top_bench;
  import ppc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, mon = 0, pwm = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [NPIN-1:0] ext_en = '0, ext_val = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NPIN-1:0] pad_in, pad_out, pad_oe, pull_up, pull_dn, analog;
  int fail_count = 0;
  int n_checks = 0;
  always #2 clk = ~clk;

  ppc_port_top DUT (.SYS_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULL_UP(pull_up),
    .PAD_PULL_DN(pull_dn), .PAD_ANALOG(analog), .RC_OSC_MONITOR(mon), .PULSE_WIDTH_OUT_CH0(pwm));
  ppc_board_model board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up),
    .pull_dn(pull_dn), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  //==========================================================
  // Reporting
  //==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    print_verdict();
  endtask

  //==========================================================
  // Bus master; ready is raised late so held read answers get seen; write ready rises with the response
  //==========================================================
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n == 1) bready <= 1'b1;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (n == 1) rready <= 1'b1;
      if (rready && rvalid) begin
        q = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) hang();
  endtask

  //==========================================================
  // Expected pad state {out, oe, pull_up, pull_dn, analog}
  //==========================================================
  function automatic logic [4:0] pin_exp(input int i, input logic dr, input logic [1:0] cfg,
                                         input logic [1:0] fs, input logic d, input logic m, input logic p);
    logic dd;
    logic [4:0] e;
    dd = d;
    e = '0;
    if (fs == FSEL_SECOND && i != PIN_RCM) e[0] = 1'b1;
    else if (fs == FSEL_SECOND) dd = m;
    else if (fs == FSEL_THIRD && i == PIN_PWM) dd = p;
    else if (fs != FSEL_GPIO) dd = 1'b0;
    if (dr == DIR_OUT) begin
      // Converter connection keeps the driver off; input pulls still follow the code
      if (!e[0]) begin
        case (cfg)
          CFG_PCH: e[4:3] = {1'b1, dd};
          CFG_NCH: e[4:3] = {1'b0, !dd};
          CFG_CMOS: e[4:3] = {dd, 1'b1};
          default: e[4:3] = 2'h0;
        endcase
      end
    end else begin
      e[2] = (cfg == CFG_PULL_UP);
      e[1] = (cfg == CFG_PULL_DN);
    end
    return {e[4] & e[3], e[3:0]};
  endfunction

  //==========================================================
  // Sequence
  //==========================================================
  initial begin
    logic [1:0] r;
    logic [31:0] q;
    logic [7:0] dir, dat, c0, c1, m0, m1;
    logic [4:0] e, sv;
    logic [ADDR_W-1:0] regs [4];
    int k;
    k = $urandom(46193);
    regs = '{ADDR_CON0, ADDR_CON1, ADDR_MOD0, ADDR_MOD1};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(pad_oe), 32'h0);
    foreach (regs[k]) begin
      rd(regs[k], q, r);
      check(q, 32'h0);
    end
    // Unmapped place must be refused
    wr(18'h00100, 32'hff, 4'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    rd(18'h00100, q, r);
    check(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_CON0, 32'h0000c3a5, 4'h3, r);
    rd(ADDR_CON1, q, r);
    check(q, 32'hc3);
    rd(ADDR_CON0, q, r);
    check(q, 32'hc3a5);
    // High lane only: the low byte keeps its value
    wr(ADDR_CON0, 32'h00005a00, 4'h2, r);
    rd(ADDR_CON0, q, r);
    check(q, 32'h5aa5);
    for (int t = 0; t < 40; t++) begin
      dir = 8'($urandom);
      dat = 8'($urandom);
      c0 = 8'($urandom);
      c1 = 8'($urandom);
      m0 = 8'($urandom);
      m1 = 8'($urandom);
      mon <= 1'($urandom);
      pwm <= 1'($urandom);
      ext_en <= dir[5:0];
      ext_val <= 6'($urandom);
      wr(ADDR_DIR, 32'(dir), 4'h1, r);
      wr(ADDR_DATA, 32'(dat), 4'h1, r);
      wr(ADDR_CON0, {16'h0, c1, c0}, 4'h3, r);
      wr(ADDR_MOD0, 32'(m0), 4'h1, r);
      wr(ADDR_MOD1, 32'(m1), 4'h1, r);
      repeat (2) @(posedge clk);
      for (int i = 0; i < NPIN; i++) begin
        e = pin_exp(i, dir[i], {c1[i], c0[i]}, {m1[i], m0[i]}, dat[i], mon, pwm);
        sv = {pad_out[i] & e[3], pad_oe[i], pull_up[i], pull_dn[i], analog[i]};
        check(32'(sv), 32'(e));
      end
      rd(ADDR_DATA, q, r);
      check(q, 32'({dat[7:6], (ext_val & dir[5:0]) | (dat[5:0] & ~dir[5:0])}));
      rd(ADDR_MOD0, q, r);
      check(q, {16'h0, m1, m0});
    end
    // Second reset mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'({pad_oe, pull_up, pull_dn}), 32'h0);
    rd(ADDR_MOD0, q, r);
    check(q, 32'h0);
    rd(ADDR_DATA, q, r);
    check(q, 32'h0);
    print_verdict();
  end
endmodule
